/* shared/cct_pkg.sv */
// Constants for the conversion-rate timing block of the analog interface device.
// Assumes one 50 MHz core clock and control inputs from logic on that clock.
// What this block does
// - A receive prescaler divides the master clock by a settable count to make the band-pass filter clock.
// - A receive divider splits the band-pass filter clock down to the A/D strobe, locked to that clock.
// - A transmit divider splits the low-pass filter clock down to the D/A strobe, locked to that clock.
// - A control setting routes the input through the band-pass filter or bypasses it.
// - A control setting picks the primary or the auxiliary differential input pair.
// - A gain setting picks unity, two or four for whichever input pair is active.
// - The divider settings vary both conversion rates, floored at 15 filter clocks per conversion (19,200 per second at 288 kHz).
// - A pulse marks each finished transfer to the processor, and in byte mode a level tells first byte from second.
// - Timing runs independent or common, and the processor may nudge each conversion period by one step while running.
// - In common timing the low-pass filter clock drives both filters and the A/D strobe equals the D/A strobe.
// - Reset initializes every internal register except the FIFO storage, the control settings included, before traffic may start.
package cct_pkg;
  localparam int unsigned CORE_CLK_HZ   = 50_000_000;
  localparam int unsigned FILT_CLK_HZ   = 288_000;
  localparam int unsigned MAX_CONV_RATE = 19_200;
  // Fewest filter clocks per conversion that keeps the rate at or below the maximum
  localparam int unsigned MIN_B_DIV     = (FILT_CLK_HZ + MAX_CONV_RATE - 1) / MAX_CONV_RATE;
  localparam int unsigned CNT_W         = 8;
  localparam int unsigned WORD_W        = 16;
  localparam int unsigned FIFO_DEPTH    = 32;
  // Reset values of counters and settings
  localparam logic [CNT_W-1:0] PRE_CNT_RST = 8'h00;
  localparam logic [CNT_W-1:0] DIV_CNT_RST = 8'h00;
  localparam logic [1:0]       GAIN_X1     = 2'h0;
  localparam logic [1:0]       GAIN_X2     = 2'h1;
  localparam logic [1:0]       GAIN_X4     = 2'h2;
  localparam logic [1:0]       GAIN_RST    = GAIN_X1;
  // Drain side of the sample path
  typedef enum logic [2:0] {
    CCT_IDLE = 3'b001,
    CCT_HI   = 3'b010,
    CCT_LO   = 3'b100
  } cct_drain_e;
endpackage

/* src/cct_timing.sv */
// Divider chain, control settings and sample output path of the conversion timing block.
// Assumes control inputs and converter data come from logic on core_clk; no synchronisers needed.
`timescale 1ns/1ps

// Plain first-word-fall-through FIFO
module cct_fifo
  import cct_pkg::*;
#(
  parameter int unsigned WIDTH = WORD_W,
  parameter int unsigned DEPTH = FIFO_DEPTH
) (
  input  wire logic             core_clk,
  input  wire logic             rst,
  input  wire logic [WIDTH-1:0] in_data,
  input  wire logic             in_valid,
  output logic                  in_ready,
  output logic      [WIDTH-1:0] out_data,
  output logic                  out_valid,
  input  wire logic             out_ready
);
  localparam int unsigned AW = $clog2(DEPTH);

  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [AW:0]                 wr;
    logic [AW:0]                 rd;
  } cct_fifo_s;

  cct_fifo_s st;
  cct_fifo_s next_st;
  logic      full;
  logic      empty;

  // Extra pointer bit tells full from empty
  assign full      = (st.wr[AW] != st.rd[AW]) && (st.wr[AW-1:0] == st.rd[AW-1:0]);
  assign empty     = (st.wr == st.rd);
  assign in_ready  = !full;
  assign out_valid = !empty;
  assign out_data  = st.mem[st.rd[AW-1:0]];

  // Push and pop may share a cycle
  always_comb begin
    next_st = st;
    if (in_valid && !full) begin
      next_st.mem[st.wr[AW-1:0]] = in_data;
      next_st.wr = st.wr + 1'b1;
    end
    if (out_ready && !empty) begin
      next_st.rd = st.rd + 1'b1;
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      st.wr  <= '0;
      st.rd  <= '0;
      st.mem <= st.mem;
    end else begin
      st <= next_st;
    end
  end
endmodule

module cct_timing
  import cct_pkg::*;
#(
  parameter int unsigned PRE_W = CNT_W,
  parameter int unsigned DIV_W = CNT_W
) (
  input  wire logic              core_clk,
  input  wire logic              rst,
  input  wire logic [PRE_W-1:0]  rx_pre_count,
  input  wire logic [PRE_W-1:0]  tx_pre_count,
  input  wire logic [DIV_W-1:0]  rx_div_count,
  input  wire logic [DIV_W-1:0]  tx_div_count,
  input  wire logic              common_timing,
  input  wire logic              rx_adj_up,
  input  wire logic              rx_adj_down,
  input  wire logic              tx_adj_up,
  input  wire logic              tx_adj_down,
  input  wire logic              filter_bypass_req,
  input  wire logic              aux_select_req,
  input  wire logic [1:0]        gain_req,
  input  wire logic              byte_mode,
  input  wire logic [WORD_W-1:0] adc_data,
  input  wire logic              overrun_clr,
  output logic                   bp_filt_en,
  output logic                   lp_filt_en,
  output logic                   adc_strobe,
  output logic                   dac_strobe,
  output logic                   filter_bypass,
  output logic                   aux_select,
  output logic [1:0]             gain,
  output logic [WORD_W-1:0]      out_data,
  output logic                   out_valid,
  input  wire logic              out_ready,
  output logic                   xfer_done,
  output logic                   second_byte,
  output logic                   overrun
);
  typedef struct packed {
    logic [PRE_W-1:0]  rx_pre;
    logic [PRE_W-1:0]  tx_pre;
    logic [DIV_W-1:0]  rx_div;
    logic [DIV_W-1:0]  tx_div;
    logic [1:0]        rx_adj;
    logic [1:0]        tx_adj;
    logic              bp_en;
    logic              lp_en;
    logic              adc_stb;
    logic              dac_stb;
    logic              bypass;
    logic              aux;
    logic [1:0]        gain;
    logic              pend_valid;
    logic [WORD_W-1:0] pend_data;
    logic              overrun;
    cct_drain_e        drain;
    logic              hold_byte;
    logic [WORD_W-1:0] hold;
    logic [WORD_W-1:0] out_data;
    logic              done;
    logic              second;
  } cct_state_s;

  cct_state_s        st;
  cct_state_s        next_st;
  logic              fifo_in_ready;
  logic [WORD_W-1:0] fifo_data;
  logic              fifo_valid;
  logic              fifo_pop;

  // Count down to zero, then reload period-1; a zero period acts as one
  function automatic logic [DIV_W-1:0] div_next(input logic [DIV_W-1:0] cnt, input logic [DIV_W-1:0] period);
    logic [DIV_W-1:0] p;
    p = (period == '0) ? DIV_W'(1) : period;
    div_next = (cnt == '0) ? p - 1'b1 : cnt - 1'b1;
  endfunction

  // Conversion period in filter clocks, floored at the fastest legal rate, nudged by one step
  function automatic logic [DIV_W-1:0] b_period(input logic [DIV_W-1:0] cnt, input logic [1:0] adj);
    logic [DIV_W-1:0] p;
    p = (cnt < DIV_W'(MIN_B_DIV)) ? DIV_W'(MIN_B_DIV) : cnt;
    if (adj == 2'b10 && p != '1) begin
      p = p + 1'b1;
    end else if (adj == 2'b01 && p > DIV_W'(MIN_B_DIV)) begin
      p = p - 1'b1;
    end
    b_period = p;
  endfunction

  assign fifo_pop = (st.drain == CCT_IDLE) && fifo_valid;

  always_comb begin
    next_st = st;
    next_st.bp_en   = 1'b0;
    next_st.lp_en   = 1'b0;
    next_st.adc_stb = 1'b0;
    next_st.dac_stb = 1'b0;
    next_st.done    = 1'b0;

    // Transmit side: prescaler makes the low-pass filter clock, divider makes the D/A strobe
    next_st.tx_pre = PRE_W'(div_next(DIV_W'(st.tx_pre), DIV_W'(tx_pre_count)));
    if (st.tx_pre == '0) begin
      next_st.lp_en  = 1'b1;
      next_st.tx_div = div_next(st.tx_div, b_period(tx_div_count, st.tx_adj));
      if (st.tx_div == '0) begin
        next_st.dac_stb = 1'b1;
      end
    end
    // Nudge waits for the next reload; a request in the reload cycle is kept
    next_st.tx_adj = ((st.tx_pre == '0 && st.tx_div == '0) ? 2'b00 : st.tx_adj)
                     | {tx_adj_up, tx_adj_down};

    if (common_timing) begin
      // One filter clock for both filters, one strobe for both converters
      next_st.bp_en   = next_st.lp_en;
      next_st.adc_stb = next_st.dac_stb;
      next_st.rx_pre  = PRE_CNT_RST;
      next_st.rx_div  = DIV_CNT_RST;
      next_st.rx_adj  = 2'b00;
    end else begin
      next_st.rx_pre = PRE_W'(div_next(DIV_W'(st.rx_pre), DIV_W'(rx_pre_count)));
      if (st.rx_pre == '0) begin
        next_st.bp_en  = 1'b1;
        next_st.rx_div = div_next(st.rx_div, b_period(rx_div_count, st.rx_adj));
        if (st.rx_div == '0) begin
          next_st.adc_stb = 1'b1;
        end
      end
      next_st.rx_adj = ((st.rx_pre == '0 && st.rx_div == '0) ? 2'b00 : st.rx_adj)
                       | {rx_adj_up, rx_adj_down};
    end

    // Input path settings; the unused gain code falls back to unity
    next_st.bypass = filter_bypass_req;
    next_st.aux    = aux_select_req;
    next_st.gain   = (gain_req == GAIN_X2 || gain_req == GAIN_X4) ? gain_req : GAIN_X1;

    // Sample waits in a holding slot while the FIFO is full; a second sample then is lost
    if (st.pend_valid && fifo_in_ready) begin
      next_st.pend_valid = 1'b0;
    end
    if (overrun_clr) begin
      next_st.overrun = 1'b0;
    end
    if (st.adc_stb) begin
      if (st.pend_valid && !fifo_in_ready) begin
        next_st.overrun = 1'b1;                                                    // set beats clear
      end else begin
        next_st.pend_valid = 1'b1;
        next_st.pend_data  = adc_data;
      end
    end

    // Drain: whole word, or high byte then low byte
    unique case (st.drain)
      CCT_IDLE: begin
        if (fifo_valid) begin
          next_st.hold      = fifo_data;
          next_st.hold_byte = byte_mode;
          next_st.out_data  = byte_mode ? {8'h00, fifo_data[15:8]} : fifo_data;
          next_st.drain     = CCT_HI;
        end
      end
      CCT_HI: begin
        if (out_ready) begin
          if (st.hold_byte) begin
            next_st.out_data = {8'h00, st.hold[7:0]};
            next_st.second   = 1'b1;
            next_st.drain    = CCT_LO;
          end else begin
            next_st.done  = 1'b1;
            next_st.drain = CCT_IDLE;
          end
        end
      end
      CCT_LO: begin
        if (out_ready) begin
          next_st.done   = 1'b1;
          next_st.second = 1'b0;
          next_st.drain  = CCT_IDLE;
        end
      end
      default: next_st.drain = CCT_IDLE;
    endcase
  end

  // Whole state cleared to initial counts while reset is high
  always_ff @(posedge core_clk) begin
    if (rst) begin
      st           <= '0;
      st.rx_pre    <= PRE_CNT_RST;
      st.tx_pre    <= PRE_CNT_RST;
      st.rx_div    <= DIV_CNT_RST;
      st.tx_div    <= DIV_CNT_RST;
      st.gain      <= GAIN_RST;
      st.drain     <= CCT_IDLE;
    end else begin
      st <= next_st;
    end
  end

  cct_fifo #(
    .WIDTH (WORD_W),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .core_clk  (core_clk),
    .rst       (rst),
    .in_data   (st.pend_data),
    .in_valid  (st.pend_valid),
    .in_ready  (fifo_in_ready),
    .out_data  (fifo_data),
    .out_valid (fifo_valid),
    .out_ready (fifo_pop)
  );

  assign bp_filt_en    = st.bp_en;
  assign lp_filt_en    = st.lp_en;
  assign adc_strobe    = st.adc_stb;
  assign dac_strobe    = st.dac_stb;
  assign filter_bypass = st.bypass;
  assign aux_select    = st.aux;
  assign gain          = st.gain;
  assign out_data      = st.out_data;
  assign out_valid     = (st.drain != CCT_IDLE);
  assign xfer_done     = st.done;
  assign second_byte   = st.second;
  assign overrun       = st.overrun;
endmodule

/* tb/cct_timing_props.sv */
// Port-level checks for the conversion timing block.
// Assumes one core_clk domain and synchronous active-high rst.
`timescale 1ns/1ps
module cct_timing_props
  import cct_pkg::*;
#(
  parameter int unsigned PRE_W = CNT_W,
  parameter int unsigned DIV_W = CNT_W
) (
  input wire logic             core_clk,
  input wire logic             rst,
  input wire logic [PRE_W-1:0] tx_pre_count,
  input wire logic             common_timing,
  input wire logic             filter_bypass_req,
  input wire logic             aux_select_req,
  input wire logic [1:0]       gain_req,
  input wire logic             bp_filt_en,
  input wire logic             lp_filt_en,
  input wire logic             adc_strobe,
  input wire logic             dac_strobe,
  input wire logic             filter_bypass,
  input wire logic             aux_select,
  input wire logic [1:0]       gain,
  input wire logic             out_valid,
  input wire logic             out_ready,
  input wire logic             xfer_done,
  input wire logic             overrun
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (rst);
  // Everything quiet on the first edge after reset
  chk_reset_clear: assert property ($past(rst) |->
    !adc_strobe && !dac_strobe && !out_valid && !overrun && !xfer_done && gain == 2'h0)
    else $error("outputs not cleared by reset");
  // Strobes only ride on a filter clock pulse, so rates stay locked
  chk_adc_on_filter: assert property (adc_strobe |-> bp_filt_en)
    else $error("adc strobe off the band-pass clock");
  chk_dac_on_filter: assert property (dac_strobe |-> lp_filt_en)
    else $error("dac strobe off the low-pass clock");
  chk_common_lock: assert property (common_timing && $past(common_timing, 2) |->
    adc_strobe == dac_strobe && bp_filt_en == lp_filt_en)
    else $error("common timing strobes differ");
  // Fifteen core clocks at least between conversions
  chk_dac_spacing: assert property (dac_strobe |=> !dac_strobe [*8] ##1 !dac_strobe [*6])
    else $error("dac strobes too close");
  chk_lp_period: assert property (lp_filt_en && tx_pre_count == 8'h02 |=> !lp_filt_en ##1 lp_filt_en)
    else $error("low-pass clock period wrong");
  chk_settings_follow: assert property (!rst |=>
    filter_bypass == $past(filter_bypass_req) && aux_select == $past(aux_select_req))
    else $error("path settings not applied");
  chk_gain_map: assert property (!rst |=> gain == (($past(gain_req) == 2'h3) ? GAIN_X1 : $past(gain_req)))
    else $error("gain setting wrong");
  chk_done_after_hs: assert property (xfer_done |-> $past(out_valid && out_ready))
    else $error("transfer done without handshake");
endmodule

bind cct_timing cct_timing_props #(.PRE_W(PRE_W), .DIV_W(DIV_W)) props_u (
  .core_clk, .rst, .tx_pre_count, .common_timing, .filter_bypass_req, .aux_select_req, .gain_req,
  .bp_filt_en, .lp_filt_en, .adc_strobe, .dac_strobe, .filter_bypass, .aux_select, .gain,
  .out_valid, .out_ready, .xfer_done, .overrun
);

/* tb/cct_sink.sv */
// Consumer model standing where the processor takes samples.
// Assumes stall and slow come from the bench; ready moves on the falling edge.
`timescale 1ns/1ps
module cct_sink (
  input  wire logic        core_clk,
  input  wire logic        rst,
  input  wire logic [15:0] out_data,
  input  wire logic        out_valid,
  input  wire logic        second_byte,
  input  wire logic        xfer_done,
  input  wire logic        stall,
  input  wire logic        slow,
  output logic             out_ready = 1'b0
);
  logic [15:0] got[$];
  logic        sb[$];
  int          dones = 0;
  // Never ready in reset; slow mode halves throughput to stretch handshakes
  always @(negedge core_clk) begin
    out_ready <= !rst && !stall && !(slow && out_ready);
  end
  // Words kept in arrival order, with the byte flag seen at each handshake
  always @(posedge core_clk) begin
    if (out_valid === 1'b1 && out_ready === 1'b1) begin
      got.push_back(out_data);
      sb.push_back(second_byte);
    end
    if (xfer_done === 1'b1) begin
      dones++;
    end
  end
endmodule

/* tb/cct_timing_test.sv */
// Self-checking bench for the conversion timing block.
// Assumes a 50 MHz core_clk; inputs move on the falling edge.
`timescale 1ns/1ps
module cct_timing_test;
  logic        core_clk = 1'b0;
  logic        rst = 1'b1;
  logic        common_timing = 1'b0, tx_adj_up = 1'b0, tx_adj_down = 1'b0, byte_mode = 1'b0;
  logic        rx_adj_up = 1'b0, rx_adj_down = 1'b0;
  logic        filter_bypass_req = 1'b0, aux_select_req = 1'b0, overrun_clr = 1'b0, stall = 1'b0, slow = 1'b0;
  logic [7:0]  rx_pre_count = 8'h01, tx_pre_count = 8'h02, rx_div_count = 8'h0f, tx_div_count = 8'h0f;
  logic [1:0]  gain_req = 2'h0;
  logic [1:0]  gain;
  logic [15:0] adc_data = 16'h0000;
  logic [15:0] out_data;
  logic        bp_filt_en, lp_filt_en, adc_strobe, dac_strobe, filter_bypass, aux_select;
  logic        out_valid, out_ready, xfer_done, second_byte, overrun;
  logic [15:0] exp_q[$];
  int          bad_count = 0, tests_run = 0, cycles = 0, n;

  cct_timing dut_u (
    .core_clk, .rst, .rx_pre_count, .tx_pre_count, .rx_div_count, .tx_div_count, .common_timing,
    .rx_adj_up, .rx_adj_down, .tx_adj_up, .tx_adj_down, .filter_bypass_req, .aux_select_req,
    .gain_req, .byte_mode, .adc_data, .overrun_clr, .bp_filt_en, .lp_filt_en, .adc_strobe, .dac_strobe,
    .filter_bypass, .aux_select, .gain, .out_data, .out_valid, .out_ready, .xfer_done, .second_byte, .overrun
  );
  cct_sink sink_u (.core_clk, .rst, .out_data, .out_valid, .second_byte, .xfer_done, .stall, .slow, .out_ready);

  initial begin
    forever #10 core_clk = ~core_clk;
  end
  // Ceiling well above the few thousand cycles the tests need
  always @(posedge core_clk) begin
    cycles++;
    if (cycles == 20000) begin
      bad_count++;
      conclude();
    end
  end
  // A fresh word for every strobe, so each captured value is known
  always @(negedge core_clk) begin
    if (adc_strobe === 1'b1) begin
      adc_data <= adc_data + 16'h1357;
      exp_q.push_back(adc_data + 16'h1357);
    end
  end

  task automatic check(string what, logic [15:0] seen, logic [15:0] want);
    tests_run++;
    if (seen !== want) begin
      bad_count++;
      $display("mismatch %s expected %h seen %h", what, want, seen);
    end
  endtask
  function automatic logic sig(int sel);
    return sel == 0 ? dac_strobe : sel == 1 ? adc_strobe : sel == 2 ? lp_filt_en : bp_filt_en;
  endfunction
  // Cycles until the chosen pulse next shows
  task automatic to_next(int sel, output int k);
    k = 0;
    do begin
      @(negedge core_clk);
      k++;
    end while (sig(sel) !== 1'b1 && k < 3000);
  endtask
  task automatic restart();
    rst = 1'b1;
    repeat (3) @(negedge core_clk);
    rst = 1'b0;
    exp_q.delete();
    sink_u.got.delete();
    sink_u.sb.delete();
    sink_u.dones = 0;
  endtask
  task automatic t_set();
    for (int i = 0; i < 4; i++) begin
      gain_req = 2'(i);
      filter_bypass_req = i[0];
      aux_select_req = i[1];
      @(negedge core_clk);
      check("gain", 16'(gain), (i == 3) ? 16'h0 : 16'(i));
      check("path", 16'({aux_select, filter_bypass}), 16'(i));
    end
    $display("test settings done");
  endtask
  task automatic t_tx();
    tx_div_count = 8'h05;
    restart();
    to_next(0, n);
    to_next(0, n);
    check("dac period clamped", 16'(n), 16'd30);
    repeat (3) @(negedge core_clk);
    tx_div_count = 8'h10;
    to_next(0, n);
    check("period in flight", 16'(n), 16'd27);
    to_next(0, n);
    check("period after reload", 16'(n), 16'd32);
    $display("test tx divider done");
  endtask
  task automatic t_adj();
    tx_div_count = 8'h0f;
    restart();
    to_next(0, n);
    repeat (3) @(negedge core_clk);
    tx_adj_up = 1'b1;
    @(negedge core_clk);
    tx_adj_up = 1'b0;
    to_next(0, n);
    check("nudge waits", 16'(n), 16'd26);
    to_next(0, n);
    check("nudged period", 16'(n), 16'd32);
    tx_adj_down = 1'b1;
    @(negedge core_clk);
    tx_adj_down = 1'b0;
    to_next(0, n);
    to_next(0, n);
    check("down nudge at floor", 16'(n), 16'd30);
    $display("test adjust done");
  endtask
  task automatic t_rx(logic common, int want);
    common_timing = common;
    rx_pre_count = 8'h03;
    rx_div_count = 8'h10;
    restart();
    to_next(1, n);
    to_next(1, n);
    check("adc period", 16'(n), 16'(want));
    to_next(3, n);
    check("bp period", 16'(n), common ? 16'd2 : 16'd3);
    // Receive nudge lengthens the next period; ignored while timing is common
    rx_adj_up = !common;
    rx_adj_down = common;
    @(negedge core_clk);
    rx_adj_up = 1'b0;
    rx_adj_down = 1'b0;
    to_next(1, n);
    to_next(1, n);
    check("adc nudged", 16'(n), common ? 16'd30 : 16'd51);
    common_timing = 1'b0;
    $display("test rx timing done");
  endtask
  task automatic t_stream(logic bytes);
    rx_pre_count = 8'h01;
    rx_div_count = 8'h0f;
    byte_mode = bytes;
    slow = bytes;
    stall = !bytes;
    restart();
    repeat (600) @(negedge core_clk);
    if (!bytes) begin
      check("overrun on full", 16'(overrun), 16'h1);
      // Let the FIFO make room first, else the next strobe sets the flag again
      stall = 1'b0;
      repeat (4) @(negedge core_clk);
      overrun_clr = 1'b1;
      @(negedge core_clk);
      overrun_clr = 1'b0;
      @(negedge core_clk);
      check("overrun cleared", 16'(overrun), 16'h0);
      repeat (200) @(negedge core_clk);
    end
    for (int i = 0; i < (bytes ? 4 : 32); i++) begin
      logic [15:0] want;
      want = (i % 2) ? {8'h00, exp_q[i / 2][7:0]} : {8'h00, exp_q[i / 2][15:8]};
      check("word order", sink_u.got[i], bytes ? want : exp_q[i]);
    end
    for (int i = 0; i < 4; i++) begin
      check("byte flag", 16'(sink_u.sb[i]), bytes ? 16'(i % 2) : 16'h0);
    end
    check("done count", 16'(sink_u.dones), 16'(bytes ? sink_u.got.size() / 2 : sink_u.got.size()));
    byte_mode = 1'b0;
    slow = 1'b0;
    $display("test stream done");
  endtask
  task automatic conclude();
    $display("checks %0d mismatches %0d", tests_run, bad_count);
    if (bad_count == 0 && tests_run > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  initial begin
    restart();
    t_set();
    t_tx();
    t_adj();
    t_rx(1'b0, 48);
    t_rx(1'b1, 30);
    t_stream(1'b0);
    t_stream(1'b1);
    conclude();
  end
endmodule
